// file: rtl/gsr_params.svh
// Constants of the rate sensor register bank: offsets, fields, resets.
// Assumes inclusion by the register bank module, its checker and its bench only.
//
// Behaviour
// - Each high/low register pair shows the upper and lower byte of one wider internal value.
// - An axis high rate register returns bits 15:8 of its signed 16-bit rate, the low one bits 7:0.
// - After reset every stored register reads zero except power control one and self-test; identity, queue level and queue data are not reset.
// - Self-test reference registers load stored factory trim at reset instead of clearing.
// - Power control one at address 107 resets to 0x01, sleep clear and clock select one.
// - The read-only identity register at address 117 always returns a fixed code.
// - Each axis's 16-bit signed offset is added to the raw rate before it is stored: user registers for Z, fixed parameters for X and Y.
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH

`define GSR_ADDR_XST      8'h00
`define GSR_ADDR_YST      8'h01
`define GSR_ADDR_ZST      8'h02
`define GSR_ADDR_ZOFFH    8'h17
`define GSR_ADDR_ZOFFL    8'h18
`define GSR_ADDR_SMPDIV   8'h19
`define GSR_ADDR_FILTCFG  8'h1a
`define GSR_ADDR_RANGE    8'h1b
`define GSR_ADDR_QSRC     8'h23
`define GSR_ADDR_FSIRQ    8'h36
`define GSR_ADDR_PINCFG   8'h37
`define GSR_ADDR_IRQEN    8'h38
`define GSR_ADDR_IRQFLG   8'h3a
`define GSR_ADDR_TEMPH    8'h41
`define GSR_ADDR_TEMPL    8'h42
`define GSR_ADDR_XRATEH   8'h43
`define GSR_ADDR_XRATEL   8'h44
`define GSR_ADDR_YRATEH   8'h45
`define GSR_ADDR_YRATEL   8'h46
`define GSR_ADDR_ZRATEH   8'h47
`define GSR_ADDR_ZRATEL   8'h48
`define GSR_ADDR_PATHRST  8'h68
`define GSR_ADDR_HOSTCTL  8'h6a
`define GSR_ADDR_PWR1     8'h6b
`define GSR_ADDR_PWR2     8'h6c
`define GSR_ADDR_QLVLH    8'h72
`define GSR_ADDR_QLVLL    8'h73
`define GSR_ADDR_QDATA    8'h74
`define GSR_ADDR_IDENT    8'h75

`define GSR_RST_ZERO      8'h00
`define GSR_RST_PWR1      8'h01
// Arbitrary neutral identity value
`define GSR_IDENT_CODE    8'h5a

`define GSR_PWR1_SLEEP    6
`define GSR_PWR1_DEVRST   7
`define GSR_FS_FLAG       7
`define GSR_FLG_DRDY      0
`define GSR_FLG_DRIVE     2
`define GSR_FLG_OFLOW     4
`define GSR_QLVL_HI_BITS  5

`endif

// file: rtl/gsr_pkg.sv
// Types of the rate sensor register bank.
// Assumes the params header sits beside it in rtl/.
package gsr_pkg;
  // One sample from the sensing path
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] xRaw;
    logic [15:0] yRaw;
    logic [15:0] zRaw;
  } gsr_sample_s;

  // Event pulses that set status flags
  typedef struct packed {
    logic frameSync;
    logic queueOverflow;
    logic driveReady;
    logic dataReady;
  } gsr_events_s;

  // Register access from the serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gsr_access_s;
endpackage : gsr_pkg

// file: rtl/gsr_register_bank.sv
// Register bank of a three-axis rate sensor.
// Assumes a serial interface front end delivering one-cycle access strobes
// and a sensing path delivering samples with a valid pulse.
`timescale 1ns/1ps
`default_nettype none
`include "gsr_params.svh"

module gsr_register_bank
  import gsr_pkg::*;
#(
  parameter logic [7:0] XST_TRIM = 8'h00,
  parameter logic [7:0] YST_TRIM = 8'h00,
  parameter logic [7:0] ZST_TRIM = 8'h00,
  parameter logic [7:0] XOFF_H   = 8'h00,
  parameter logic [7:0] XOFF_L   = 8'h00,
  parameter logic [7:0] YOFF_H   = 8'h00,
  parameter logic [7:0] YOFF_L   = 8'h00
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Host register access
  input  wire gsr_access_s access,
  output logic [7:0]       rdata,
  // Sensing path
  input  wire gsr_sample_s sample,
  input  wire logic        sampleValid,
  input  wire gsr_events_s events,
  input  wire logic [12:0] queueLevel,
  input  wire logic [7:0]  queueReadData,
  // Control to the rest of the device
  output logic [7:0]       sample_rate_divider,
  output logic [7:0]       filter_sync_config,
  output logic [7:0]       rate_range_config,
  output logic [7:0]       queue_source_enable,
  output logic [7:0]       irq_pin_config,
  output logic [7:0]       irq_enable_mask,
  output logic [7:0]       path_reset_control,
  output logic [7:0]       host_control,
  output logic [7:0]       power_control_one,
  output logic [7:0]       power_control_two,
  output logic             sleepMode,
  output logic [7:0]       queueWriteData,
  output logic             queueWrite,
  output logic             queueRead
);

  // Internal registers: writable ones, flags and sample values
  logic [7:0]  x_selftest_reference;
  logic [7:0]  y_selftest_reference;
  logic [7:0]  z_selftest_reference;
  logic [7:0]  z_user_offset_high;
  logic [7:0]  z_user_offset_low;
  logic [7:0]  frame_sync_irq_status;
  logic [7:0]  irq_flags;
  logic [15:0] temperature;
  logic [15:0] x_rate_value;
  logic [15:0] y_rate_value;
  logic [15:0] z_rate_value;

  // Decode
  wire wrEn = access.wr;
  wire rdEn = access.rd;
  wire [7:0] a = access.addr;
  wire [7:0] d = access.wdata;
  wire wrXst   = wrEn && a == `GSR_ADDR_XST;
  wire wrYst   = wrEn && a == `GSR_ADDR_YST;
  wire wrZst   = wrEn && a == `GSR_ADDR_ZST;
  wire wrZoffH = wrEn && a == `GSR_ADDR_ZOFFH;
  wire wrZoffL = wrEn && a == `GSR_ADDR_ZOFFL;
  wire wrDiv   = wrEn && a == `GSR_ADDR_SMPDIV;
  wire wrFilt  = wrEn && a == `GSR_ADDR_FILTCFG;
  wire wrRange = wrEn && a == `GSR_ADDR_RANGE;
  wire wrQsrc  = wrEn && a == `GSR_ADDR_QSRC;
  wire wrPin   = wrEn && a == `GSR_ADDR_PINCFG;
  wire wrIrqEn = wrEn && a == `GSR_ADDR_IRQEN;
  wire wrPath  = wrEn && a == `GSR_ADDR_PATHRST;
  wire wrHost  = wrEn && a == `GSR_ADDR_HOSTCTL;
  wire wrPwr1  = wrEn && a == `GSR_ADDR_PWR1;
  wire wrPwr2  = wrEn && a == `GSR_ADDR_PWR2;
  wire wrQdata = wrEn && a == `GSR_ADDR_QDATA;
  wire rdFs    = rdEn && a == `GSR_ADDR_FSIRQ;
  wire rdFlg   = rdEn && a == `GSR_ADDR_IRQFLG;

  // Device reset bit acts like the reset pin except that rdata is not cleared, one cycle after the write
  wire softRst = power_control_one[`GSR_PWR1_DEVRST];
  wire anyRst  = rst || softRst;

  // Offset path
  wire [15:0] xOffset = {XOFF_H, XOFF_L};
  wire [15:0] yOffset = {YOFF_H, YOFF_L};
  wire [15:0] zOffset = {z_user_offset_high, z_user_offset_low};
  // Wraps rather than saturates, as a plain 16-bit adder
  wire [15:0] xSum = sample.xRaw + xOffset;
  wire [15:0] ySum = sample.yRaw + yOffset;
  wire [15:0] zSum = sample.zRaw + zOffset;

  // Flag updates: set wins over read clear
  wire [7:0] flagSet = {3'b000, events.queueOverflow, 1'b0,
                        events.driveReady, 1'b0, events.dataReady};
  wire [7:0] fsSet   = {events.frameSync, 7'b0000000};
  wire [7:0] next_irq_flags = (rdFlg ? `GSR_RST_ZERO : irq_flags)
                              | flagSet;
  wire [7:0] next_frame_sync = (rdFs ? `GSR_RST_ZERO : frame_sync_irq_status)
                               | fsSet;

  // Trim reloads on either reset, so a device reset restores it
  always_ff @(posedge clk) begin
    if (anyRst) begin
      x_selftest_reference <= XST_TRIM;
    end else if (wrXst) begin
      x_selftest_reference <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      y_selftest_reference <= YST_TRIM;
    end else if (wrYst) begin
      y_selftest_reference <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      z_selftest_reference <= ZST_TRIM;
    end else if (wrZst) begin
      z_selftest_reference <= d;
    end
  end

  // One short block per register, all cleared by either reset
  always_ff @(posedge clk) begin
    if (anyRst) begin
      z_user_offset_high <= `GSR_RST_ZERO;
    end else if (wrZoffH) begin
      z_user_offset_high <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      z_user_offset_low <= `GSR_RST_ZERO;
    end else if (wrZoffL) begin
      z_user_offset_low <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      sample_rate_divider <= `GSR_RST_ZERO;
    end else if (wrDiv) begin
      sample_rate_divider <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      filter_sync_config <= `GSR_RST_ZERO;
    end else if (wrFilt) begin
      filter_sync_config <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      rate_range_config <= `GSR_RST_ZERO;
    end else if (wrRange) begin
      rate_range_config <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      queue_source_enable <= `GSR_RST_ZERO;
    end else if (wrQsrc) begin
      queue_source_enable <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      irq_pin_config <= `GSR_RST_ZERO;
    end else if (wrPin) begin
      irq_pin_config <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      irq_enable_mask <= `GSR_RST_ZERO;
    end else if (wrIrqEn) begin
      irq_enable_mask <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      path_reset_control <= `GSR_RST_ZERO;
    end else if (wrPath) begin
      path_reset_control <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      host_control <= `GSR_RST_ZERO;
    end else if (wrHost) begin
      host_control <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      power_control_two <= `GSR_RST_ZERO;
    end else if (wrPwr2) begin
      power_control_two <= d;
    end
  end

  // Device reset bit self-clears through the reset it causes
  always_ff @(posedge clk) begin
    if (anyRst) begin
      power_control_one <= `GSR_RST_PWR1;
    end else if (wrPwr1) begin
      power_control_one <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      irq_flags <= `GSR_RST_ZERO;
    end else begin
      irq_flags <= next_irq_flags;
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      frame_sync_irq_status <= `GSR_RST_ZERO;
    end else begin
      frame_sync_irq_status <= next_frame_sync;
    end
  end

  // Outputs stay frozen while asleep; sample strobe ignored
  always_ff @(posedge clk) begin
    if (anyRst) begin
      temperature  <= 16'h0000;
      x_rate_value <= 16'h0000;
      y_rate_value <= 16'h0000;
      z_rate_value <= 16'h0000;
    end else if (sampleValid && !sleepMode) begin
      temperature  <= sample.temp;
      x_rate_value <= xSum;
      y_rate_value <= ySum;
      z_rate_value <= zSum;
    end
  end

  assign sleepMode      = power_control_one[`GSR_PWR1_SLEEP];
  assign queueRead      = rdEn && a == `GSR_ADDR_QDATA;

  // Queue write leaves a cycle late, strobe and data from flops together
  always_ff @(posedge clk) begin
    if (anyRst) begin
      queueWrite     <= 1'b0;
      queueWriteData <= `GSR_RST_ZERO;
    end else begin
      queueWrite <= wrQdata;
      if (wrQdata) queueWriteData <= d;
    end
  end

  // Read select: one hit per mapped address
  wire hitXst    = a == `GSR_ADDR_XST;
  wire hitYst    = a == `GSR_ADDR_YST;
  wire hitZst    = a == `GSR_ADDR_ZST;
  wire hitZoffH  = a == `GSR_ADDR_ZOFFH;
  wire hitZoffL  = a == `GSR_ADDR_ZOFFL;
  wire hitDiv    = a == `GSR_ADDR_SMPDIV;
  wire hitFilt   = a == `GSR_ADDR_FILTCFG;
  wire hitRange  = a == `GSR_ADDR_RANGE;
  wire hitQsrc   = a == `GSR_ADDR_QSRC;
  wire hitFs     = a == `GSR_ADDR_FSIRQ;
  wire hitPin    = a == `GSR_ADDR_PINCFG;
  wire hitIrqEn  = a == `GSR_ADDR_IRQEN;
  wire hitFlg    = a == `GSR_ADDR_IRQFLG;
  wire hitTempH  = a == `GSR_ADDR_TEMPH;
  wire hitTempL  = a == `GSR_ADDR_TEMPL;
  wire hitXrateH = a == `GSR_ADDR_XRATEH;
  wire hitXrateL = a == `GSR_ADDR_XRATEL;
  wire hitYrateH = a == `GSR_ADDR_YRATEH;
  wire hitYrateL = a == `GSR_ADDR_YRATEL;
  wire hitZrateH = a == `GSR_ADDR_ZRATEH;
  wire hitZrateL = a == `GSR_ADDR_ZRATEL;
  wire hitPath   = a == `GSR_ADDR_PATHRST;
  wire hitHost   = a == `GSR_ADDR_HOSTCTL;
  wire hitPwr1   = a == `GSR_ADDR_PWR1;
  wire hitPwr2   = a == `GSR_ADDR_PWR2;
  wire hitLvlH   = a == `GSR_ADDR_QLVLH;
  wire hitLvlL   = a == `GSR_ADDR_QLVLL;
  wire hitQdata  = a == `GSR_ADDR_QDATA;
  wire hitIdent  = a == `GSR_ADDR_IDENT;
  // Unmapped reads miss every term and give zero
  wire [7:0] next_rdata =
      ({8{hitXst}}    & x_selftest_reference)
    | ({8{hitYst}}    & y_selftest_reference)
    | ({8{hitZst}}    & z_selftest_reference)
    | ({8{hitZoffH}}  & zOffset[15:8])
    | ({8{hitZoffL}}  & zOffset[7:0])
    | ({8{hitDiv}}    & sample_rate_divider)
    | ({8{hitFilt}}   & filter_sync_config)
    | ({8{hitRange}}  & rate_range_config)
    | ({8{hitQsrc}}   & queue_source_enable)
    | ({8{hitFs}}     & frame_sync_irq_status)
    | ({8{hitPin}}    & irq_pin_config)
    | ({8{hitIrqEn}}  & irq_enable_mask)
    | ({8{hitFlg}}    & irq_flags)
    | ({8{hitTempH}}  & temperature[15:8])
    | ({8{hitTempL}}  & temperature[7:0])
    | ({8{hitXrateH}} & x_rate_value[15:8])
    | ({8{hitXrateL}} & x_rate_value[7:0])
    | ({8{hitYrateH}} & y_rate_value[15:8])
    | ({8{hitYrateL}} & y_rate_value[7:0])
    | ({8{hitZrateH}} & z_rate_value[15:8])
    | ({8{hitZrateL}} & z_rate_value[7:0])
    | ({8{hitPath}}   & path_reset_control)
    | ({8{hitHost}}   & host_control)
    | ({8{hitPwr1}}   & power_control_one)
    | ({8{hitPwr2}}   & power_control_two)
    | ({8{hitLvlH}}   & {3'b000, queueLevel[12:8]})
    | ({8{hitLvlL}}   & queueLevel[7:0])
    | ({8{hitQdata}}  & queueReadData)
    | ({8{hitIdent}}  & `GSR_IDENT_CODE);

  // Read data registered; holds until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= `GSR_RST_ZERO;
    end else if (rdEn) begin
      rdata <= next_rdata;
    end
  end

endmodule : gsr_register_bank
`default_nettype wire

// file: sim/gsr_register_bank_asserts.sv
// Checker of the rate sensor register bank, on its ports only.
// Assumes binding to gsr_register_bank, params header on the path.
`timescale 1ns/1ps
`default_nettype none
`include "gsr_params.svh"
module gsr_register_bank_asserts
  import gsr_pkg::*;
#(
  parameter logic [7:0] XOFF_H = 8'h00,
  parameter logic [7:0] XOFF_L = 8'h00
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Host access
  input wire gsr_access_s access,
  input wire logic [7:0]  rdata,
  // Sensing path
  input wire gsr_sample_s sample,
  input wire logic        sampleValid,
  input wire gsr_events_s events,
  input wire logic [12:0] queueLevel,
  // Power control
  input wire logic [7:0]  power_control_one,
  input wire logic        sleepMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic        rdOn = access.rd;
  wire logic [7:0]  rdAt = access.addr;
  wire logic        fresh = sampleValid && !sleepMode;
  wire logic [15:0] xOff = {XOFF_H, XOFF_L};

  a_pwr_reset_one: assert property (
    $fell(rst) |-> power_control_one == 8'h01) else $error("pwr reset");
  a_rdata_reset_zero: assert property (
    $fell(rst) |-> rdata == 8'h00) else $error("rdata reset");
  a_ident_fixed: assert property (
    rdOn && rdAt == 8'h75 |=> rdata == `GSR_IDENT_CODE) else $error("ident");
  a_level_high: assert property (
    rdOn && rdAt == 8'h72 |=> rdata == {3'b000, $past(queueLevel[12:8])})
    else $error("level high");
  a_level_low: assert property (
    rdOn && rdAt == 8'h73 |=> rdata == $past(queueLevel[7:0]))
    else $error("level low");
  a_xrate_high: assert property (
    fresh ##1 (rdOn && rdAt == 8'h43 && !sampleValid)
    |=> rdata == 8'(($past(sample.xRaw, 2) + xOff) >> 8)) else $error("xh");
  a_xrate_low: assert property (
    fresh ##1 (rdOn && rdAt == 8'h44 && !sampleValid)
    |=> rdata == 8'($past(sample.xRaw, 2) + xOff)) else $error("xl");
  a_flags_read_clear: assert property (
    (rdOn && rdAt == 8'h3a && events == '0) ##1 (rdOn && rdAt == 8'h3a)
    |=> rdata == 8'h00) else $error("flags kept");
endmodule : gsr_register_bank_asserts

bind gsr_register_bank gsr_register_bank_asserts #(
  .XOFF_H(XOFF_H), .XOFF_L(XOFF_L)
) u_checker (
  .clk(clk), .rst(rst), .access(access), .rdata(rdata), .sample(sample),
  .sampleValid(sampleValid), .events(events), .queueLevel(queueLevel),
  .power_control_one(power_control_one), .sleepMode(sleepMode)
);
`default_nettype wire

// file: sim/gsr_host_model.sv
// Host model: one-cycle write strobes, two-cycle read strobes giving reads back to back.
// Assumes read data registered and valid after the read edge.
`timescale 1ns/1ps
`default_nettype none
module gsr_host_model
  import gsr_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register access
  output var gsr_access_s access,
  input  wire logic [7:0] rdata
);
  initial access = '0;
  // Released lines show the inverse, so a stale value never passes
  task automatic drop(input gsr_access_s a);
    access <= '{1'b0, 1'b0, ~a.addr, ~a.wdata};
  endtask : drop
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk) access <= '{1'b1, 1'b0, a, w};
    @(posedge clk) drop(access);
    #1;
  endtask : wr
  // Two reads on consecutive edges
  task automatic rd(input logic [7:0] a, output logic [7:0] d1, d2);
    @(posedge clk) access <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) #1 d1 = rdata;
    @(posedge clk) drop(access);
    #1 d2 = rdata;
  endtask : rd
  // Clock select kept at one
  task automatic wake();
    wr(8'h6b, 8'h01);
  endtask : wake
endmodule : gsr_host_model
`default_nettype wire

// file: sim/gsr_register_bank_test.sv
// Bench of the rate sensor register bank, table-driven host accesses.
// Assumes host model and checker compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "gsr_params.svh"
module gsr_register_bank_test;
  import gsr_pkg::*;
  localparam logic [7:0] XT = 8'h3c, YT = 8'h4d, ZT = 8'h5e;
  localparam logic [7:0] XH = 8'h01, XL = 8'hf0;
  localparam logic [7:0] RA [30] = '{8'h00, 8'h01, 8'h02, 8'h6b, 8'h75,
    8'h03, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b, 8'h23, 8'h36, 8'h37, 8'h38,
    8'h3a, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h68,
    8'h6a, 8'h6c, 8'h72, 8'h73, 8'h74};
  localparam logic [7:0] RE [30] = '{0: XT, 1: YT, 2: ZT, 3: 8'h01,
    4: `GSR_IDENT_CODE, default: 8'h00};
  localparam logic [7:0] WA [11] = '{8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b,
    8'h23, 8'h37, 8'h38, 8'h68, 8'h6a, 8'h6c};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  gsr_access_s access;
  gsr_sample_s sample = '0;
  gsr_events_s events = '0;
  logic        sampleValid = 1'b0;
  logic        sleepOut, qWr;
  logic [12:0] queueLevel = '0;
  logic [7:0]  rdata, pwrOne, d, d2, qWd;
  logic [8:0][7:0] ctl;
  logic [15:0] v [4];
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;

  always #4 clk = ~clk;

  gsr_register_bank #(
    .XST_TRIM(XT), .YST_TRIM(YT), .ZST_TRIM(ZT), .XOFF_H(XH), .XOFF_L(XL)
  ) DUT (
    .clk(clk), .rst(rst), .access(access), .rdata(rdata), .sample(sample),
    .sampleValid(sampleValid), .events(events), .queueLevel(queueLevel),
    .queueReadData(8'h00), .sample_rate_divider(ctl[0]),
    .filter_sync_config(ctl[1]), .rate_range_config(ctl[2]),
    .queue_source_enable(ctl[3]), .irq_pin_config(ctl[4]),
    .irq_enable_mask(ctl[5]), .path_reset_control(ctl[6]),
    .host_control(ctl[7]), .power_control_one(pwrOne),
    .power_control_two(ctl[8]), .sleepMode(sleepOut),
    .queueWriteData(qWd), .queueWrite(qWr), .queueRead()
  );
  gsr_host_model host (.clk(clk), .access(access), .rdata(rdata));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Valid drops at the edge where a following read is launched
  task automatic smp(input gsr_sample_s s);
    @(posedge clk) begin
      sample <= s;
      sampleValid <= 1'b1;
    end
    fork
      @(posedge clk) sampleValid <= 1'b0;
    join_none
  endtask : smp

  // Generous ceiling, the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (RA[i]) if (i < 6 || RA[i] == 8'h3a || RA[i] == 8'h43)
      host.wr(RA[i], 8'hff);
    foreach (RA[i]) begin
      host.rd(RA[i], d, d2);
      chk(d, RE[i]);
    end
    foreach (WA[i]) host.wr(WA[i], WA[i] ^ 8'h3c);
    foreach (WA[i]) begin
      host.rd(WA[i], d, d2);
      chk(d, WA[i] ^ 8'h3c);
      if (i > 1) chk(ctl[i - 2], WA[i] ^ 8'h3c);
    end
    host.wr(8'h6b, 8'h40);
    chk({7'h00, sleepOut}, 8'h01);
    smp('{16'h1111, 16'h2222, 16'h3333, 16'h4444});
    host.rd(8'h43, d, d2);
    chk(d, 8'h00);
    host.wake();
    chk(pwrOne, 8'h01);
    // Z offset is the pair written above, X wraps past 16 bits
    v = '{16'h8001, 16'hff20 + {XH, XL}, 16'h7fff, 16'h0102 + 16'h2b24};
    for (int i = 0; i < 8; i++) begin
      smp('{16'h8001, 16'hff20, 16'h7fff, 16'h0102});
      host.rd(8'h41 + 8'(i), d, d2);
      chk(d, i[0] ? v[i / 2][7:0] : v[i / 2][15:8]);
    end
    @(posedge clk) queueLevel <= 13'h1abc;
    host.rd(8'h72, d, d2);
    chk(d, 8'h1a);
    host.rd(8'h73, d, d2);
    chk(d, 8'hbc);
    @(posedge clk) events <= '{1'b1, 1'b1, 1'b1, 1'b1};
    @(posedge clk) events <= '0;
    host.rd(8'h3a, d, d2);
    chk(d, 8'h15);
    chk(d2, 8'h00);
    host.rd(8'h36, d, d2);
    chk(d, 8'h80);
    chk(d2, 8'h00);
    host.wr(8'h74, 8'h5b);
    chk(qWd, 8'h5b);
    chk({7'h00, qWr}, 8'h01);
    @(posedge clk) #1 chk({7'h00, qWr}, 8'h00);
    host.wr(8'h6b, 8'h80);
    host.rd(8'h19, d, d2);
    chk(d, 8'h00);
    host.rd(8'h6b, d, d2);
    chk(d, 8'h01);
    for (int i = 0; i < 9; i++) chk(ctl[i], 8'h00);
    chk(qWd, 8'h00);
    complete_run();
  end
endmodule : gsr_register_bank_test
`default_nettype wire
